// ### inc/dci_pkg.sv
package dci_pkg;

  localparam int WORD_W = 24;
  localparam int REG_AW = 8;

  // instruction classes live in word[23:20]
  typedef enum logic [3:0] {
    CLS_NOP      = 4'h0,
    CLS_FILE     = 4'h1,
    CLS_BIT      = 4'h2,
    CLS_LIT      = 4'h3,
    CLS_CBRANCH  = 4'h4,
    CLS_RBRANCH  = 4'h5,
    CLS_INDIRECT = 4'h6,
    CLS_TABLE    = 4'h7,
    CLS_RETURN   = 4'h8,
    CLS_SKIP     = 4'h9,
    CLS_MOVD     = 4'ha,
    CLS_MAC      = 4'hb,
    CLS_GOTO     = 4'hc,
    CLS_MOVLIT   = 4'hd,
    CLS_ALU      = 4'he,
    CLS_CALL     = 4'hf
  } dci_cls_type;

  typedef enum logic [1:0] {
    ST_FETCH  = 2'b00,
    ST_SECOND = 2'b01,
    ST_STALL  = 2'b11,
    ST_SKIP2  = 2'b10
  } dci_state_type;

  typedef enum logic [1:0] {
    WB_NONE = 2'b00,
    WB_REG  = 2'b01,
    WB_MEM  = 2'b10,
    WB_BAD  = 2'b11
  } dci_accwb_type;

  // cycle counts per class
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_TAKEN = 2'h2;
  localparam logic [1:0] CYC_RBRANCH = 2'h2;
  localparam logic [1:0] CYC_INDIRECT = 2'h2;
  localparam logic [1:0] CYC_TABLE = 2'h2;
  localparam logic [1:0] CYC_RETURN = 2'h3;
  localparam logic [1:0] CYC_DOUBLE = 2'h2;
  localparam logic [1:0] CYC_MOVD = 2'h2;

  // operand limits and fixed registers
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0ff;
  localparam logic [12:0] FILE_ADDR_MAX = 13'h1fff;
  localparam logic [3:0] FILE_WORK_REG = 4'h0;
  localparam logic [3:0] WB_WORK_REG = 4'hd;
  localparam logic [3:0] WB_POST_INC = 4'h2;
  localparam logic [3:0] MUL_BASE_REG = 4'h4;
  localparam logic [3:0] X_BASE_LO = 4'h8;
  localparam logic [3:0] Y_BASE_LO = 4'ha;
  localparam logic [3:0] INDEX_REG = 4'hc;
  localparam logic [3:0] PF_MODES = 4'h7;
  localparam logic [3:0] PF_INDEXED = 4'he;
  localparam logic [3:0] PF_NONE = 4'hf;
  localparam logic [7:0] SECOND_HI_ZERO = 8'h00;

  // register map
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_FLAGS = 8'h04;
  localparam logic [REG_AW-1:0] REG_LAST = 8'h08;
  localparam logic [REG_AW-1:0] REG_ERR = 8'h0c;
  localparam logic RST_CTRL_EN = 1'b1;
  localparam logic [7:0] RST_ERR_CNT = 8'h00;

  typedef struct packed {
    logic c;
    logic digit_carry_flag;
    logic n;
    logic overflow_flag;
    logic z;
  } dci_arith_type;

  typedef struct packed {
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic acc_a_saturate_flag;
    logic acc_b_saturate_flag;
  } dci_dsp_type;

  typedef struct packed {
    logic arith_upd;
    logic z_sticky;
    logic result_zero;
    dci_arith_type arith;
    logic dsp_upd;
    dci_dsp_type dsp;
  } dci_flag_upd_type;

  typedef struct packed {
    logic none;
    logic indexed;
    logic [3:0] base;
    logic [3:0] index;
    logic signed [3:0] post;
  } dci_prefetch_type;

  typedef struct packed {
    dci_cls_type cls;
    logic byte_mode;
    logic acc_sel;
    logic [3:0] base_work_reg;
    logic [3:0] src_work_reg;
    logic [3:0] dest_work_reg;
    logic [3:0] bit_select_field;
    logic [12:0] file_addr;
    logic [15:0] imm;
    logic [22:0] program_addr_imm;
    dci_prefetch_type x_prefetch_addr;
    dci_prefetch_type y_prefetch_addr;
    logic [3:0] x_dest;
    logic [3:0] y_dest;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    dci_accwb_type acc_writeback_dest;
    logic error;
  } dci_dec_type;

endpackage : dci_pkg

// ### design/dci_decoder.sv
// Notes on behaviour
// - double-word instruction spans two program words
// - second word top byte zero; alone NOP
// - double-word instruction takes two cycles
// - single-word one cycle; taken/PC-change two
// - branches, indirect, table, returns take two-three
// - taken skip: two or three by skipped size
// - double-word move takes two cycles
// - writeback to W13 or [W13] plus two
// - bit select four bits, zero to fifteen
// - file operand spans zero to 0x1FFF
// - unsigned ten-bit literal, byte mode 255 max
// - program address literal has zero lsb
// - signed literals two's complement, ten/sixteen bits
// - file instructions use working register zero
// - square pairs only W4..W7 by itself
// - multiply pairs: six distinct from W4..W7
// - X prefetch W8/W9 modes, W9+W12, none
// - Y prefetch W10/W11 modes, W11+W12, none
// - prefetch destinations are W4 through W7
// - overflow and saturate flags per accumulator
// - carry, digit carry, negative, overflow, sticky zero
// - register fields pick one of sixteen
module dci_decoder
  import dci_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic [WORD_W-1:0] word_data,
  output logic word_ready,
  input wire logic cond_true,
  input wire logic skip_true,
  input wire dci_flag_upd_type flag_upd,
  output logic insn_done,
  output logic [1:0] insn_cycles,
  output dci_dec_type dec_out,
  output dci_arith_type arith_flags,
  output dci_dsp_type dsp_flags,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  typedef struct packed {
    dci_state_type st;
    logic [1:0] stall;
    logic [1:0] tot;
    logic skip;
    dci_dec_type dec;
    logic done;
    logic [1:0] last_cyc;
    dci_cls_type last_cls;
    logic ctrl_en;
    dci_arith_type arith;
    dci_dsp_type dsp;
    logic err_sticky;
    logic [7:0] err_cnt;
    logic [31:0] rdata;
  } dci_core_type;

  dci_core_type s_q;
  dci_core_type s_d;

  // prefetch field: 7 modes on the low base, 7 on the high, indexed, none
  function automatic dci_prefetch_type pf_decode(input logic [3:0] code,
                                                 input logic [3:0] lo_base);
    dci_prefetch_type p;
    logic [3:0] m;
    p = '0;
    m = (code < PF_MODES) ? code : code - PF_MODES;
    if (code == PF_NONE) begin
      p.none = 1'b1;
    end else if (code == PF_INDEXED) begin
      p.indexed = 1'b1;
      p.base = lo_base + 4'h1;
      p.index = INDEX_REG;
    end else begin
      p.base = (code < PF_MODES) ? lo_base : lo_base + 4'h1;
      case (m)
        4'h0: p.post = 4'sh6;
        4'h1: p.post = 4'sh4;
        4'h2: p.post = 4'sh2;
        4'h3: p.post = 4'sh0;
        4'h4: p.post = -4'sh6;
        4'h5: p.post = -4'sh4;
        default: p.post = -4'sh2;
      endcase
    end
    return p;
  endfunction : pf_decode

  function automatic logic is_double(input dci_cls_type c);
    return (c == CLS_GOTO) || (c == CLS_CALL);
  endfunction : is_double

  function automatic dci_dec_type decode(input logic [WORD_W-1:0] w);
    dci_dec_type d;
    d = '0;
    d.cls = dci_cls_type'(w[23:20]);
    d.byte_mode = w[19];
    case (d.cls)
      CLS_FILE: begin
        d.file_addr = w[12:0];
        d.error = (w[12:0] > FILE_ADDR_MAX);
        d.dest_work_reg = FILE_WORK_REG;
        d.src_work_reg = FILE_WORK_REG;
      end
      CLS_BIT: begin
        d.bit_select_field = w[15:12];
        d.base_work_reg = w[11:8];
      end
      CLS_LIT: begin
        d.imm = {6'h00, w[13:4]};
        d.dest_work_reg = w[3:0];
        d.error = w[19] && (w[13:4] > BYTE_LIT_MAX);
      end
      CLS_CBRANCH, CLS_RBRANCH: begin
        d.imm = {{6{w[13]}}, w[13:4]};
      end
      CLS_INDIRECT, CLS_TABLE, CLS_MOVD: begin
        d.src_work_reg = w[7:4];
        d.dest_work_reg = w[3:0];
      end
      CLS_MOVLIT: begin
        d.imm = w[19:4];
        d.dest_work_reg = w[3:0];
        d.byte_mode = 1'b0;
      end
      CLS_ALU: begin
        d.base_work_reg = w[11:8];
        d.src_work_reg = w[7:4];
        d.dest_work_reg = w[3:0];
      end
      CLS_GOTO, CLS_CALL: begin
        d.program_addr_imm = {7'h00, w[15:0]};
        d.byte_mode = 1'b0;
      end
      CLS_MAC: begin
        d.acc_sel = w[16];
        d.byte_mode = 1'b0;
        d.acc_writeback_dest = dci_accwb_type'(w[18:17]);
        if (d.acc_writeback_dest != WB_NONE) begin
          d.dest_work_reg = WB_WORK_REG;
        end
        d.mul_a = MUL_BASE_REG + {2'b00, w[15:14]};
        d.mul_b = MUL_BASE_REG + {2'b00, w[13:12]};
        d.x_prefetch_addr = pf_decode(w[11:8], X_BASE_LO);
        d.y_prefetch_addr = pf_decode(w[7:4], Y_BASE_LO);
        d.x_dest = MUL_BASE_REG + {2'b00, w[3:2]};
        d.y_dest = MUL_BASE_REG + {2'b00, w[1:0]};
        if (d.acc_writeback_dest == WB_BAD) begin
          d.error = 1'b1;
        end else if (w[19]) begin
          d.error = (w[15:14] != w[13:12]);
        end else begin
          d.error = (w[15:14] >= w[13:12]);
        end
      end
      default: begin
        d.byte_mode = 1'b0;
      end
    endcase
    return d;
  endfunction : decode

  // whole-instruction cycle count as seen at the first word
  function automatic logic [1:0] cycles_for(input dci_cls_type c, input logic taken);
    logic [1:0] n;
    case (c)
      CLS_CBRANCH: n = taken ? CYC_TAKEN : CYC_SINGLE;
      CLS_RBRANCH: n = CYC_RBRANCH;
      CLS_INDIRECT: n = CYC_INDIRECT;
      CLS_TABLE: n = CYC_TABLE;
      CLS_RETURN: n = CYC_RETURN;
      CLS_MOVD: n = CYC_MOVD;
      CLS_GOTO, CLS_CALL: n = CYC_DOUBLE;
      default: n = CYC_SINGLE;
    endcase
    return n;
  endfunction : cycles_for

  logic take;
  dci_dec_type fetched;

  // fetch holds off in stall cycles, so the extra cycles run as no-ops
  assign word_ready = s_q.ctrl_en && (s_q.st != ST_STALL);
  assign take = word_ready && word_valid;
  assign fetched = decode(word_data);

  always_comb begin
    logic finish;
    logic [1:0] fin_cyc;
    logic [1:0] total;
    logic new_err;
    finish = 1'b0;
    new_err = 1'b0;
    fin_cyc = s_q.tot;
    total = cycles_for(fetched.cls, cond_true);
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdata = '0;

    case (s_q.st)
      ST_FETCH: begin
        if (take && s_q.skip) begin
          // skipped word runs as a no-op cycle
          s_d.skip = 1'b0;
          s_d.tot = s_q.tot + 2'h1;
          if (is_double(fetched.cls)) begin
            s_d.st = ST_SKIP2;
          end else begin
            finish = 1'b1;
            fin_cyc = s_q.tot + 2'h1;
          end
        end else if (take) begin
          s_d.dec = fetched;
          s_d.tot = total;
          if (is_double(fetched.cls)) begin
            s_d.st = ST_SECOND;
          end else if (fetched.cls == CLS_SKIP && skip_true) begin
            s_d.skip = 1'b1;
            s_d.tot = CYC_SINGLE;
          end else if (total == CYC_SINGLE) begin
            finish = 1'b1;
            fin_cyc = total;
          end else begin
            // extra cycles stall fetch and execute as no-ops
            s_d.st = ST_STALL;
            s_d.stall = total - 2'h1;
          end
        end
      end
      ST_SECOND: begin
        if (take) begin
          // upper address bits ride in the second word; its top byte must stay clear
          s_d.dec.program_addr_imm = {word_data[6:0], s_q.dec.program_addr_imm[15:0]};
          if (word_data[23:16] != SECOND_HI_ZERO) begin
            s_d.dec.error = 1'b1;
          end
          if (s_q.dec.program_addr_imm[0]) begin
            s_d.dec.error = 1'b1;
          end
          s_d.st = ST_FETCH;
          finish = 1'b1;
        end
      end
      ST_STALL: begin
        s_d.stall = s_q.stall - 2'h1;
        if (s_q.stall == 2'h1) begin
          s_d.st = ST_FETCH;
          finish = 1'b1;
        end
      end
      default: begin
        if (take) begin
          s_d.tot = s_q.tot + 2'h1;
          s_d.st = ST_FETCH;
          finish = 1'b1;
          fin_cyc = s_q.tot + 2'h1;
        end
      end
    endcase

    if (finish) begin
      s_d.done = 1'b1;
      s_d.last_cyc = fin_cyc;
      s_d.last_cls = s_q.st == ST_FETCH && !s_q.skip ? fetched.cls : s_q.dec.cls;
      if (s_d.dec.error && !(s_q.st == ST_FETCH && s_q.skip)) begin
        s_d.err_sticky = 1'b1;
        s_d.err_cnt = s_q.err_cnt + 8'h01;
        new_err = 1'b1;
      end
    end

    // register writes; hardware flag updates below take precedence
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        s_d.ctrl_en = reg_wdata[0];
      end else if (reg_addr == REG_FLAGS) begin
        s_d.arith = dci_arith_type'(reg_wdata[4:0]);
        s_d.dsp = dci_dsp_type'(reg_wdata[11:8]);
      end else if (reg_addr == REG_ERR) begin
        // an error landing with the clear survives it, so none goes uncounted
        if (reg_wdata[0] && !new_err) begin
          s_d.err_sticky = 1'b0;
        end
        if (reg_wdata[1]) begin
          s_d.err_cnt = new_err ? 8'h01 : RST_ERR_CNT;
        end
      end
    end

    if (flag_upd.arith_upd) begin
      s_d.arith = flag_upd.arith;
      // sticky zero can only be cleared by a nonzero result
      s_d.arith.z = flag_upd.z_sticky ? (s_q.arith.z & flag_upd.result_zero)
                                      : flag_upd.result_zero;
    end
    if (flag_upd.dsp_upd) begin
      s_d.dsp = flag_upd.dsp;
    end

    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        s_d.rdata = {31'h00000000, s_q.ctrl_en};
      end else if (reg_addr == REG_FLAGS) begin
        s_d.rdata = {20'h00000, s_q.dsp, 3'h0, s_q.arith};
      end else if (reg_addr == REG_LAST) begin
        s_d.rdata = {24'h000000, s_q.st, s_q.last_cyc, s_q.last_cls};
      end else if (reg_addr == REG_ERR) begin
        s_d.rdata = {16'h0000, s_q.err_cnt, 7'h00, s_q.err_sticky};
      end else begin
        s_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.ctrl_en <= RST_CTRL_EN;
      s_q.err_cnt <= RST_ERR_CNT;
    end else begin
      s_q <= s_d;
    end
  end

  assign insn_done = s_q.done;
  assign insn_cycles = s_q.last_cyc;
  assign dec_out = s_q.dec;
  assign arith_flags = s_q.arith;
  assign dsp_flags = s_q.dsp;
  assign reg_rdata = s_q.rdata;

endmodule : dci_decoder

// ### tb/dci_decoder_asserts.sv
module dci_decoder_asserts
  import dci_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic [WORD_W-1:0] word_data,
  input wire logic word_ready,
  input wire logic cond_true,
  input wire logic skip_true,
  input wire dci_flag_upd_type flag_upd,
  input wire logic insn_done,
  input wire logic [1:0] insn_cycles,
  input wire dci_dec_type dec_out,
  input wire dci_arith_type arith_flags,
  input wire dci_dsp_type dsp_flags,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic fresh_q;
  logic take;
  logic go;
  logic dbl;
  logic [3:0] c;
  assign take = word_valid && word_ready;
  assign c = word_data[23:20];
  assign dbl = c == CLS_GOTO || c == CLS_CALL;
  assign go = take && fresh_q;
  // second words and skipped words must not be read as new instructions
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fresh_q <= 1'b1;
    end else if (take) begin
      fresh_q <= !(dbl || (fresh_q && c == CLS_SKIP && skip_true));
    end
  end
  a_single_one:
    assert property (go && (c inside {CLS_NOP, CLS_FILE, CLS_BIT, CLS_LIT, CLS_MAC, CLS_MOVLIT,
      CLS_ALU} || (c == CLS_CBRANCH && !cond_true) || (c == CLS_SKIP && !skip_true))
      |=> insn_done && insn_cycles == 2'h1) else $error("single cycle count wrong");
  a_taken_two:
    assert property (go && c == CLS_CBRANCH && cond_true |-> ##1 !word_ready
      ##1 (insn_done && insn_cycles == 2'h2)) else $error("taken branch count wrong");
  a_fixed_two:
    assert property (go && c inside {CLS_RBRANCH, CLS_INDIRECT, CLS_TABLE, CLS_MOVD}
      |-> ##1 !word_ready ##1 (insn_done && insn_cycles == 2'h2)) else $error("two cycle wrong");
  a_return_three:
    assert property (go && c == CLS_RETURN |-> ##1 !word_ready[*2]
      ##1 (insn_done && insn_cycles == 2'h3)) else $error("return count wrong");
  a_double_two:
    assert property (go && dbl ##1 take |=> insn_done && insn_cycles == 2'h2)
      else $error("double word count wrong");
  a_skip_over:
    assert property (go && c == CLS_SKIP && skip_true ##1 (take && dbl) ##1 take
      |=> insn_done && insn_cycles == 2'h3) else $error("skip over double wrong");
  a_skip_single:
    assert property (go && c == CLS_SKIP && skip_true ##1 (take && !dbl)
      |=> insn_done && insn_cycles == 2'h2) else $error("skip over single wrong");
  a_second_top:
    assert property (go && dbl ##1 (take && word_data[23:16] != 8'h00) |=> dec_out.error)
      else $error("second word top byte accepted");
  a_addr_lsb:
    assert property (go && dbl && word_data[0] ##1 take |=> dec_out.error)
      else $error("odd program address accepted");
  a_mac_pairs:
    assert property (go && c == CLS_MAC && (word_data[19] ? word_data[15:14] != word_data[13:12]
      : word_data[15:14] >= word_data[13:12]) |=> dec_out.error) else $error("bad pair accepted");
  a_awb_legal:
    assert property (go && c == CLS_MAC && word_data[18:17] == 2'h3 |=> dec_out.error)
      else $error("bad writeback accepted");
  a_byte_lit:
    assert property (go && c == CLS_LIT && word_data[19] && word_data[13:4] > 10'h0ff
      |=> dec_out.error) else $error("byte literal over range accepted");
  a_flags_arith:
    assert property (flag_upd.arith_upd && !flag_upd.z_sticky
      |=> arith_flags == {$past(flag_upd.arith[4:1]), $past(flag_upd.result_zero)})
      else $error("arith flags not updated");
  a_zero_sticky:
    assert property (flag_upd.arith_upd && flag_upd.z_sticky && !arith_flags.z
      |=> !arith_flags.z) else $error("sticky zero set by a zero result");
  a_flags_dsp:
    assert property (flag_upd.dsp_upd |=> dsp_flags == $past(flag_upd.dsp))
      else $error("dsp flags not updated");
  c_return: cover property (go && c == CLS_RETURN);
  c_skip_dbl: cover property (go && c == CLS_SKIP && skip_true ##1 (take && dbl));
  c_double: cover property (go && dbl ##1 take);
  c_sticky: cover property (flag_upd.arith_upd && flag_upd.z_sticky);
endmodule : dci_decoder_asserts

bind dci_decoder dci_decoder_asserts dci_decoder_asserts_i (.mclk, .reset_n, .word_valid,
  .word_data, .word_ready, .cond_true, .skip_true, .flag_upd, .insn_done, .insn_cycles,
  .dec_out, .arith_flags, .dsp_flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// ### tb/tb_top.sv
module tb_top
  import dci_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic word_valid = 1'b0;
  logic [WORD_W-1:0] word_data = '0;
  logic cond_true = 1'b0;
  logic skip_true = 1'b0;
  dci_flag_upd_type flag_upd = '0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic word_ready;
  logic insn_done;
  logic [1:0] insn_cycles;
  dci_dec_type dec_out;
  dci_arith_type arith_flags;
  dci_dsp_type dsp_flags;
  logic [31:0] reg_rdata;
  int err_total = 0;
  int checks = 0;
  int exp_errs = 0;
  int sent = 0;
  logic [15:0] seed = 16'h6537;
  logic [23:0] corner [7] = '{24'hbc5ff0, 24'hb29ff0, 24'hb61ff0, 24'hb01e60, 24'h380ff0,
    24'h381000, 24'h303ff0};

  dci_decoder dci_decoder_i (.mclk, .reset_n, .word_valid, .word_data, .word_ready, .cond_true,
    .skip_true, .flag_upd, .insn_done, .insn_cycles, .dec_out, .arith_flags, .dsp_flags,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [1:0] exp_cyc(input logic [23:0] w, input logic ct);
    case (w[23:20])
      CLS_CBRANCH: return ct ? 2'h2 : 2'h1;
      CLS_RBRANCH, CLS_INDIRECT, CLS_TABLE, CLS_MOVD: return 2'h2;
      CLS_RETURN: return 2'h3;
      default: return 2'h1;
    endcase
  endfunction : exp_cyc

  function automatic logic exp_err(input logic [23:0] w);
    case (w[23:20])
      CLS_LIT: return w[19] && w[13:4] > 10'h0ff;
      CLS_MAC: return w[18:17] == 2'h3 || (w[19] ? w[15:14] != w[13:12] : w[15:14] >= w[13:12]);
      default: return 1'b0;
    endcase
  endfunction : exp_err

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic send(input logic [23:0] w, input logic ct, input logic st);
    word_valid <= 1'b1;
    word_data <= w;
    cond_true <= ct;
    skip_true <= st;
    sent++;
    do @(posedge mclk); while (word_ready !== 1'b1);
  endtask : send

  // counts edges from the last take to completion
  task automatic finish(input logic [1:0] exp, input logic e);
    int n;
    n = 0;
    word_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (insn_done !== 1'b1 && n < 8);
    // earlier words of the instruction already used up part of its cycles
    check(n, 32'(int'(exp) + 1 - sent));
    check(32'(insn_cycles), 32'(exp));
    check(32'(dec_out.error), 32'(e));
    exp_errs += int'(e);
    sent = 0;
  endtask : finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end

  initial begin : main
    logic [31:0] d;
    logic [23:0] w;
    dci_flag_upd_type f;
    logic z;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(REG_CTRL, d);
    check(d, 32'h1);
    rd(8'h10, d);
    check(d, 32'h0);
    wr(REG_CTRL, 32'h0);
    check(32'(word_ready), 32'h0);
    wr(REG_CTRL, 32'h1);
    $display("register test done");
    repeat (200) begin
      seed = lfsr(seed);
      w[23:8] = seed;
      seed = lfsr(seed);
      w[7:0] = seed[7:0];
      // double words and skips run as directed cases below
      if (w[23:20] inside {CLS_GOTO, CLS_CALL, CLS_SKIP}) w[23:20] = CLS_ALU;
      send(w, seed[9], 1'b0);
      finish(exp_cyc(w, seed[9]), exp_err(w));
      case (w[23:20])
        CLS_FILE: check(32'(dec_out.file_addr), 32'(w[12:0]));
        CLS_BIT: check(32'(dec_out.bit_select_field), 32'(w[15:12]));
        CLS_MOVLIT: check(32'(dec_out.imm), 32'(w[19:4]));
        CLS_ALU: check(32'(dec_out.dest_work_reg), 32'(w[3:0]));
        default: ;
      endcase
    end
    $display("random stream test done");
    for (int i = 0; i < 3; i++) begin
      send(i == 2 ? 24'hf01234 : 24'hc01234 | 24'(i == 1), 1'b0, 1'b0);
      send(i == 2 ? 24'h010055 : 24'h000055, 1'b0, 1'b0);
      finish(2'h2, i != 0);
      if (i == 0) check(32'(dec_out.program_addr_imm), 32'h551234);
    end
    send(24'h900000, 1'b0, 1'b0);
    finish(2'h1, 1'b0);
    send(24'h900000, 1'b0, 1'b1);
    send(24'h000000, 1'b0, 1'b0);
    finish(2'h2, 1'b0);
    send(24'h900000, 1'b0, 1'b1);
    send(24'hc00010, 1'b0, 1'b0);
    send(24'h000000, 1'b0, 1'b0);
    finish(2'h3, 1'b0);
    foreach (corner[i]) begin
      send(corner[i], 1'b0, 1'b0);
      finish(2'h1, exp_err(corner[i]));
      if (i == 0) check(32'(dec_out.acc_writeback_dest), 32'(WB_MEM));
    end
    rd(REG_LAST, d);
    check(d, {24'h0, ST_FETCH, 2'h1, CLS_LIT});
    $display("directed decode test done");
    rd(REG_ERR, d);
    check({d[15:8], 7'h0, d[0]}, {8'(exp_errs), 7'h0, exp_errs != 0});
    wr(REG_ERR, 32'h3);
    rd(REG_ERR, d);
    check(d & 32'hff01, 32'h0);
    seed = lfsr(seed);
    f = (seed[12:0] | 13'h1010) & 13'h17ff;
    flag_upd <= f;
    @(posedge mclk);
    flag_upd <= '0;
    @(posedge mclk);
    // a plain update takes zero from the result, not from the flag field
    z = f.result_zero;
    check(32'({dsp_flags, arith_flags}), 32'({f.dsp, f.arith[4:1], z}));
    rd(REG_FLAGS, d);
    check(d & 32'hf1f, {20'h0, f.dsp, 3'h0, f.arith[4:1], z});
    f.z_sticky = 1'b1;
    f.result_zero = 1'b1;
    flag_upd <= f;
    @(posedge mclk);
    flag_upd <= '0;
    @(posedge mclk);
    check(32'(arith_flags), 32'({f.arith[4:1], z}));
    f.result_zero = 1'b0;
    flag_upd <= f;
    @(posedge mclk);
    flag_upd <= '0;
    @(posedge mclk);
    check(32'(arith_flags.z), 32'h0);
    $display("flag test done");
    results();
  end
endmodule : tb_top
